// ### hdl/plt_area_decode.sv
// Purpose: classify a word address into its memory area
// Assumes: SMALL_USER selects the reduced user memory size
// Notes: addresses in the gaps classify as no area
`timescale 1ns/100ps
module plt_area_decode
  import plt_pkg::*;
#(
  parameter bit SMALL_USER = 1'b0
) (
  plt_area_if.decoder port
);

  logic [ADDR_W-1:0] userEnd;
  assign userEnd = SMALL_USER ? USER_END_SMALL : USER_END_LARGE;

  // area limits; 8-bit areas start at the first cpu8 word
  always_comb begin
    if (port.addr <= userEnd) begin
      port.area = AR_USER;
    end else if (port.addr >= CPU16_START && port.addr <= CPU16_END) begin
      port.area = AR_CPU16;
    end else if (port.addr >= CPU8_START && port.addr <= CPU8_END) begin
      port.area = AR_CPU8;
    end else if (port.addr >= IO8_START) begin
      port.area = AR_IO8;
    end else begin
      port.area = AR_NONE;
    end
  end

  // everything from the cpu8 start upward is byte-wide memory
  assign port.byteWide = (port.addr >= CPU8_START);

endmodule // plt_area_decode

// ### hdl/plt_area_if.sv
// Purpose: carries an address to the area decoder and its classification back
// Assumes: one decoder per client
// Notes: purely combinational path
`timescale 1ns/100ps
interface plt_area_if;
  import plt_pkg::*;
  logic [ADDR_W-1:0] addr;
  plt_area_t area;
  logic byteWide;
  modport client(output addr, input area, input byteWide);
  modport decoder(input addr, output area, output byteWide);
endinterface // plt_area_if

// ### hdl/plt_bcd_convert.sv
// Purpose: binary to three-digit bcd for timer and counter values
// Assumes: input value at most 999
// Notes: shift-and-add-three, fully combinational
`timescale 1ns/100ps
module plt_bcd_convert
  import plt_pkg::*;
(
  input logic [CNT_VALUE_W-1:0] bin,
  output logic [BCD_W-1:0] bcd
);

  // one shift per input bit, each digit corrected before the shift
  always_comb begin
    logic [BCD_W-1:0] acc;
    acc = '0;
    for (int i = CNT_VALUE_W - 1; i >= 0; i--) begin
      for (int d = 0; d < BCD_W / 4; d++) begin
        if (acc[d*4 +: 4] > 4'h4) begin
          acc[d*4 +: 4] = acc[d*4 +: 4] + 4'h3;
        end
      end
      acc = {acc[BCD_W-2:0], bin[i]};
    end
    bcd = acc;
  end

endmodule // plt_bcd_convert

// ### hdl/plt_load_transfer_unit.sv
// Purpose: executes load, transfer, indirect register, block copy and stack push
// Assumes: one memory port, same clock as the unit, request held until ack
// Notes: accumulators and internal registers are held here
// Notes on behaviour
// - formal load puts input, output, timer or counter value into accumulator 1
// - coded load puts timer or counter value into accumulator 1 as bcd
// - pattern fetch copies constant bit pattern unchanged into accumulator 1
// - float constant bit pattern is also loaded unchanged into accumulator 1
// - formal store writes accumulator 1 to byte, word or doubleword operand
// - load one interface or system area word, index 0 to 255, into accumulator 1
// - store accumulator 1 into interface or system area word, index 0 to 255
// - indirect fetch fills register 0 to 15 from memory word addressed by accumulator 1
// - indirect store writes register 0 to 15 to memory word addressed by accumulator 1
// - every indirectly reachable register is 16 bits wide
// - register numbers map onto accumulator halves, block stack pointer, data block base and step pointer
// - register numbers 4, 7, 8, 13, 14 make the instruction a no operation
// - indirect store into 8-bit memory writes only the low byte
// - indirect fetch from 8-bit memory sets register high byte to all ones
// - block copies move 0 to 255 bytes or words, source accu 2, destination accu 1
// - accumulators 2 and 1 hold the source and destination end addresses
// - memory areas are user, 16-bit cpu, 8-bit cpu and 8-bit io
// - stack push copies accumulator 3 into accumulator 4
`timescale 1ns/100ps
module plt_load_transfer_unit
  import plt_pkg::*;
#(
  parameter bit SMALL_USER = 1'b0
) (
  input logic clk,
  input logic reset_n,
  input logic cmdValid,
  input plt_op_t cmdOp,
  input plt_size_t cmdSize,
  input logic [PARAM_W-1:0] cmdParam,
  input logic [ADDR_W-1:0] cmdAddr,
  input logic [ACC_W-1:0] cmdOperand,
  output logic cmdReady,
  output logic cmdDone,
  output logic memReq,
  output logic memWrite,
  output logic memByte,
  output plt_space_t memSpace,
  output logic [ADDR_W-1:0] memAddr,
  output logic [WORD_W-1:0] memWdata,
  input logic [WORD_W-1:0] memRdata,
  input logic memAck,
  output logic [ACC_W-1:0] accu1,
  output logic [ACC_W-1:0] accu2,
  output logic [ACC_W-1:0] accu3,
  output logic [ACC_W-1:0] accu4,
  output logic [WORD_W-1:0] stepPointer,
  output logic [WORD_W-1:0] blockStackPtr,
  output logic [WORD_W-1:0] dataBlockBase
);

  plt_state_t state;
  plt_op_t op;
  plt_size_t opSize;
  logic [REGNUM_W-1:0] opReg;
  logic secondWord;
  logic [PARAM_W-1:0] count;
  logic [ADDR_W-1:0] srcAddr;
  logic [ADDR_W-1:0] dstAddr;
  logic [WORD_W-1:0] hiHold;
  logic [BCD_W-1:0] bcdValue;
  logic [WORD_W-1:0] regValue;
  logic regPresent;
  logic cmdStart;
  logic readFinal;
  logic isCopy;
  logic [WORD_W-1:0] fetchedWord;

  plt_area_if accuArea ();

  // indirect accesses classify the address held in accumulator 1
  assign accuArea.addr = accu1[WORD_W-1:0];

  plt_area_decode #(
    .SMALL_USER(SMALL_USER)
  ) u_area (
    .port(accuArea.decoder)
  );

  plt_bcd_convert u_bcd (
    .bin(memRdata[CNT_VALUE_W-1:0]),
    .bcd(bcdValue)
  );

  assign cmdStart = (state == ST_IDLE) && cmdValid && cmdReady;
  assign isCopy = (op == OP_BYTE_COPY) || (op == OP_WORD_COPY);
  // last read of an instruction that ends in a register update
  assign readFinal = (state == ST_READ) && memAck && !isCopy
                     && !(op == OP_FORMAL_LOAD && opSize == SZ_DWORD && !secondWord);
  assign regPresent = REG_PRESENT_MASK[cmdParam[REGNUM_W-1:0]];
  assign fetchedWord = memByte ? {BYTE_FILL, memRdata[7:0]} : memRdata;

  // 16-bit view of every register reachable by number
  always_comb begin
    unique case (cmdParam[REGNUM_W-1:0])
      REG_ACCU1_HIGH: regValue = accu1[ACC_W-1:WORD_W];
      REG_ACCU1_LOW: regValue = accu1[WORD_W-1:0];
      REG_ACCU2_HIGH: regValue = accu2[ACC_W-1:WORD_W];
      REG_ACCU2_LOW: regValue = accu2[WORD_W-1:0];
      REG_BLOCK_STACK: regValue = blockStackPtr;
      REG_DATA_BLOCK: regValue = dataBlockBase;
      REG_ACCU3_HIGH: regValue = accu3[ACC_W-1:WORD_W];
      REG_ACCU3_LOW: regValue = accu3[WORD_W-1:0];
      REG_ACCU4_HIGH: regValue = accu4[ACC_W-1:WORD_W];
      REG_ACCU4_LOW: regValue = accu4[WORD_W-1:0];
      REG_STEP_PTR: regValue = stepPointer;
      default: regValue = WORD_ZERO; // absent numbers never reach memory
    endcase
  end

  // sequencer: command acceptance, memory requests and completion
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      op <= OP_FORMAL_LOAD;
      opSize <= SZ_WORD;
      opReg <= '0;
      secondWord <= 1'b0;
      count <= COUNT_ZERO;
      srcAddr <= REG16_RESET;
      dstAddr <= REG16_RESET;
      hiHold <= REG16_RESET;
      cmdReady <= 1'b0;
      cmdDone <= 1'b0;
      memReq <= 1'b0;
      memWrite <= 1'b0;
      memByte <= 1'b0;
      memSpace <= SP_MAIN;
      memAddr <= REG16_RESET;
      memWdata <= WORD_ZERO;
    end else begin
      unique case (state)
        ST_IDLE: begin
          cmdDone <= 1'b0;
          cmdReady <= 1'b1;
          if (cmdStart) begin
            op <= cmdOp;
            opSize <= cmdSize;
            opReg <= cmdParam[REGNUM_W-1:0];
            secondWord <= 1'b0;
            cmdReady <= 1'b0;
            memSpace <= SP_MAIN;
            memByte <= 1'b0;
            case (cmdOp)
              OP_FORMAL_LOAD, OP_BCD_COUNT_LOAD: begin
                memReq <= 1'b1;
                memWrite <= 1'b0;
                memAddr <= cmdAddr;
                state <= ST_READ;
              end
              OP_FORMAL_STORE: begin
                memReq <= 1'b1;
                memWrite <= 1'b1;
                memAddr <= cmdAddr;
                memByte <= (cmdSize == SZ_BYTE);
                // doubleword goes high word first, then low word
                if (cmdSize == SZ_DWORD) begin
                  memWdata <= accu1[ACC_W-1:WORD_W];
                end else if (cmdSize == SZ_BYTE) begin
                  memWdata <= {BYTE_ZERO, accu1[7:0]};
                end else begin
                  memWdata <= accu1[WORD_W-1:0];
                end
                state <= ST_WRITE;
              end
              OP_IF_LOAD, OP_SYS_LOAD, OP_IF_STORE, OP_SYS_STORE: begin
                memReq <= 1'b1;
                memSpace <= (cmdOp == OP_IF_LOAD || cmdOp == OP_IF_STORE)
                            ? SP_INTERFACE : SP_SYSTEM;
                memAddr <= {BYTE_ZERO, cmdParam};
                memWrite <= (cmdOp == OP_IF_STORE || cmdOp == OP_SYS_STORE);
                memWdata <= accu1[WORD_W-1:0];
                state <= (cmdOp == OP_IF_STORE || cmdOp == OP_SYS_STORE)
                         ? ST_WRITE : ST_READ;
              end
              OP_IREG_FETCH, OP_IREG_STORE: begin
                if (regPresent) begin
                  memReq <= 1'b1;
                  memAddr <= accu1[WORD_W-1:0];
                  memByte <= accuArea.byteWide;
                  memWrite <= (cmdOp == OP_IREG_STORE);
                  // byte-wide memory only takes the low byte
                  memWdata <= accuArea.byteWide ? {BYTE_ZERO, regValue[7:0]} : regValue;
                  state <= (cmdOp == OP_IREG_STORE) ? ST_WRITE : ST_READ;
                end else begin
                  state <= ST_FINISH; // no operation
                end
              end
              OP_BYTE_COPY, OP_WORD_COPY: begin
                // end addresses come from the accumulators
                srcAddr <= accu2[WORD_W-1:0];
                dstAddr <= accu1[WORD_W-1:0];
                count <= cmdParam;
                memByte <= (cmdOp == OP_BYTE_COPY);
                memWrite <= 1'b0;
                memAddr <= accu2[WORD_W-1:0];
                if (cmdParam == COUNT_ZERO) begin
                  state <= ST_FINISH; // zero length moves nothing
                end else begin
                  memReq <= 1'b1;
                  state <= ST_READ;
                end
              end
              default: state <= ST_FINISH; // register-only instructions
            endcase
          end
        end
        ST_READ: begin
          if (memAck) begin
            if (op == OP_FORMAL_LOAD && opSize == SZ_DWORD && !secondWord) begin
              hiHold <= memRdata;
              secondWord <= 1'b1;
              memAddr <= memAddr + ADDR_STEP;
            end else if (isCopy) begin
              memWrite <= 1'b1;
              memAddr <= dstAddr;
              memWdata <= memByte ? {BYTE_ZERO, memRdata[7:0]} : memRdata;
              state <= ST_WRITE;
            end else begin
              memReq <= 1'b0;
              state <= ST_FINISH;
            end
          end
        end
        ST_WRITE: begin
          if (memAck) begin
            if (op == OP_FORMAL_STORE && opSize == SZ_DWORD && !secondWord) begin
              secondWord <= 1'b1;
              memAddr <= memAddr + ADDR_STEP;
              memWdata <= accu1[WORD_W-1:0];
            end else if (isCopy && count != COUNT_STEP) begin
              // walk both areas downward one element at a time
              count <= count - COUNT_STEP;
              srcAddr <= srcAddr - ADDR_STEP;
              dstAddr <= dstAddr - ADDR_STEP;
              memAddr <= srcAddr - ADDR_STEP;
              memWrite <= 1'b0;
              state <= ST_READ;
            end else begin
              if (isCopy) begin
                count <= COUNT_ZERO;
              end
              memReq <= 1'b0;
              memWrite <= 1'b0;
              state <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          cmdDone <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // accumulators and internal 16-bit registers; loads push accu 1 into accu 2
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      accu1 <= ACC_RESET;
      accu2 <= ACC_RESET;
      accu3 <= ACC_RESET;
      accu4 <= ACC_RESET;
      stepPointer <= REG16_RESET;
      blockStackPtr <= REG16_RESET;
      dataBlockBase <= REG16_RESET;
    end else if (cmdStart) begin
      if (cmdOp == OP_PATTERN_FETCH || cmdOp == OP_FLOAT_FETCH) begin
        accu2 <= accu1;
        accu1 <= cmdOperand; // raw pattern, no conversion
      end else if (cmdOp == OP_STACK_PUSH) begin
        accu4 <= accu3;
        accu3 <= accu2;
      end
    end else if (readFinal) begin
      case (op)
        OP_FORMAL_LOAD: begin
          accu2 <= accu1;
          if (opSize == SZ_DWORD) begin
            accu1 <= {hiHold, memRdata};
          end else if (opSize == SZ_BYTE) begin
            accu1 <= {WORD_ZERO, BYTE_ZERO, memRdata[7:0]};
          end else begin
            accu1 <= {WORD_ZERO, memRdata};
          end
        end
        OP_BCD_COUNT_LOAD: begin
          accu2 <= accu1;
          // time base kept beside the bcd value
          accu1 <= {WORD_ZERO, 2'b00, memRdata[CNT_BASE_LSB +: CNT_BASE_W], bcdValue};
        end
        OP_IF_LOAD, OP_SYS_LOAD: begin
          accu2 <= accu1;
          accu1 <= {WORD_ZERO, memRdata};
        end
        OP_IREG_FETCH: begin
          case (opReg)
            REG_ACCU1_HIGH: accu1[ACC_W-1:WORD_W] <= fetchedWord;
            REG_ACCU1_LOW: accu1[WORD_W-1:0] <= fetchedWord;
            REG_ACCU2_HIGH: accu2[ACC_W-1:WORD_W] <= fetchedWord;
            REG_ACCU2_LOW: accu2[WORD_W-1:0] <= fetchedWord;
            REG_BLOCK_STACK: blockStackPtr <= fetchedWord;
            REG_DATA_BLOCK: dataBlockBase <= fetchedWord;
            REG_ACCU3_HIGH: accu3[ACC_W-1:WORD_W] <= fetchedWord;
            REG_ACCU3_LOW: accu3[WORD_W-1:0] <= fetchedWord;
            REG_ACCU4_HIGH: accu4[ACC_W-1:WORD_W] <= fetchedWord;
            REG_ACCU4_LOW: accu4[WORD_W-1:0] <= fetchedWord;
            REG_STEP_PTR: stepPointer <= fetchedWord;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_start(plt_op_t o);
    (state == ST_IDLE) && cmdValid && cmdReady && (cmdOp == o);
  endsequence

  sequence s_finish;
    (state == ST_FINISH) ##1 cmdDone;
  endsequence

  a_push_acc4: assert property (s_start(OP_STACK_PUSH) |=> accu4 == $past(accu3))
    else $error("push did not move accu 3 into accu 4");
  a_push_keep_low: assert property (s_start(OP_STACK_PUSH) |=>
      accu3 == $past(accu2) && $stable(accu1) && $stable(accu2))
    else $error("push disturbed accu 1 or 2 or missed accu 3");
  a_pattern_load: assert property (s_start(OP_PATTERN_FETCH) |=>
      accu1 == $past(cmdOperand) && accu2 == $past(accu1))
    else $error("pattern fetch did not load accu 1");
  a_float_load: assert property (s_start(OP_FLOAT_FETCH) |=>
      accu1 == $past(cmdOperand) ##1 cmdDone)
    else $error("float pattern not loaded unchanged");
  a_gap_nop: assert property ((s_start(OP_IREG_FETCH) or s_start(OP_IREG_STORE))
      ##0 !regPresent |=> !memReq throughout s_finish)
    else $error("absent register number caused a memory access");
  a_byte_store: assert property (memReq && memWrite && op == OP_IREG_STORE
      && memByte |-> memWdata[15:8] == BYTE_ZERO && memAddr >= CPU8_START)
    else $error("high byte sent to byte-wide memory");
  a_fetch_fill: assert property (readFinal && op == OP_IREG_FETCH && memByte
      && opReg == REG_ACCU1_LOW |=> accu1[15:8] == BYTE_FILL)
    else $error("byte-wide fetch did not fill high byte");
  a_copy_down: assert property (state == ST_WRITE && memAck && isCopy
      && count > COUNT_STEP |=> state == ST_READ && memAddr == $past(srcAddr) - ADDR_STEP)
    else $error("copy did not step downward");
  a_copy_zero: assert property (s_start(OP_WORD_COPY) ##0 cmdParam == COUNT_ZERO
      |=> s_finish)
    else $error("zero-length copy did not finish at once");
  a_if_index: assert property (s_start(OP_IF_LOAD) |=> memReq
      && memSpace == SP_INTERFACE && memAddr == {BYTE_ZERO, $past(cmdParam)})
    else $error("interface word request malformed");
  a_area_width: assert property (memReq && (op == OP_IREG_FETCH || op == OP_IREG_STORE)
      |-> memByte == (accuArea.area inside {AR_CPU8, AR_IO8}))
    else $error("indirect access width disagrees with memory area");

endmodule // plt_load_transfer_unit

// ### hdl/plt_pkg.sv
// Purpose: shared constants and types for the load/transfer execution unit
// Assumes: word-addressed 16-bit memory space, 32-bit accumulators
// Notes: register numbers, area limits and fill values live here only
package plt_pkg;

  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;
  localparam int ACC_W = 32;
  localparam int PARAM_W = 8;
  localparam int REGNUM_W = 4;

  // instruction codes presented on the command port
  typedef enum logic [3:0] {
    OP_FORMAL_LOAD = 4'h0,
    OP_BCD_COUNT_LOAD = 4'h1,
    OP_PATTERN_FETCH = 4'h2,
    OP_FLOAT_FETCH = 4'h3,
    OP_FORMAL_STORE = 4'h4,
    OP_IF_LOAD = 4'h5,
    OP_SYS_LOAD = 4'h6,
    OP_IF_STORE = 4'h7,
    OP_SYS_STORE = 4'h8,
    OP_IREG_FETCH = 4'h9,
    OP_IREG_STORE = 4'hA,
    OP_BYTE_COPY = 4'hB,
    OP_WORD_COPY = 4'hC,
    OP_STACK_PUSH = 4'hD
  } plt_op_t;

  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_DWORD = 2'h2} plt_size_t;
  typedef enum logic [1:0] {SP_MAIN = 2'h0, SP_INTERFACE = 2'h1, SP_SYSTEM = 2'h2} plt_space_t;
  typedef enum logic [2:0] {
    AR_USER = 3'h0, AR_CPU16 = 3'h1, AR_CPU8 = 3'h2, AR_IO8 = 3'h3, AR_NONE = 3'h4
  } plt_area_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_READ = 4'b0010, ST_WRITE = 4'b0100, ST_FINISH = 4'b1000
  } plt_state_t;

  // indirect register numbers
  localparam logic [3:0] REG_ACCU1_HIGH = 4'h0;
  localparam logic [3:0] REG_ACCU1_LOW = 4'h1;
  localparam logic [3:0] REG_ACCU2_HIGH = 4'h2;
  localparam logic [3:0] REG_ACCU2_LOW = 4'h3;
  localparam logic [3:0] REG_BLOCK_STACK = 4'h5;
  localparam logic [3:0] REG_DATA_BLOCK = 4'h6;
  localparam logic [3:0] REG_ACCU3_HIGH = 4'h9;
  localparam logic [3:0] REG_ACCU3_LOW = 4'hA;
  localparam logic [3:0] REG_ACCU4_HIGH = 4'hB;
  localparam logic [3:0] REG_ACCU4_LOW = 4'hC;
  localparam logic [3:0] REG_STEP_PTR = 4'hF;
  // one bit per register number, clear where no register exists (4,7,8,13,14)
  localparam logic [15:0] REG_PRESENT_MASK = 16'h9E6F;

  // memory area limits
  localparam logic [15:0] USER_END_LARGE = 16'h7FFF;
  localparam logic [15:0] USER_END_SMALL = 16'h3FFF;
  localparam logic [15:0] CPU16_START = 16'hAC00;
  localparam logic [15:0] CPU16_END = 16'hEDFF;
  localparam logic [15:0] CPU8_START = 16'hEE00;
  localparam logic [15:0] CPU8_END = 16'hEFFF;
  localparam logic [15:0] IO8_START = 16'hF000;

  localparam logic [7:0] BYTE_FILL = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  // timer/counter word: binary value low, time base field above it
  localparam int CNT_VALUE_W = 10;
  localparam int CNT_BASE_LSB = 12;
  localparam int CNT_BASE_W = 2;
  localparam int BCD_W = 12;

endpackage

// ### testbench/plt_load_transfer_unit_tb.sv
// Purpose: self-checking bench for the load/transfer unit
// Assumes: memory model answers after 0 to 3 wait cycles
// Notes: mirror holds 16 register slots; accumulators are slot pairs
`timescale 1ns/100ps
module plt_load_transfer_unit_tb;
  import plt_pkg::*;
  logic clk, reset_n, cmdValid, cmdReady, cmdDone, memReq, memWrite, memByte, memAck;
  plt_op_t cmdOp;
  plt_size_t cmdSize;
  plt_space_t memSpace;
  logic [7:0] cmdParam;
  logic [15:0] cmdAddr, memAddr, memWdata, memRdata, stepPointer, blockStackPtr, dataBlockBase;
  logic [31:0] cmdOperand, accu1, accu2, accu3, accu4, seed, v;
  logic [15:0] rg [16];
  logic [15:0] mm [logic [17:0]];
  logic [17:0] k;
  int fails, compares;
  bit trust;
  plt_load_transfer_unit uut (.clk, .reset_n, .cmdValid, .cmdOp, .cmdSize, .cmdParam,
    .cmdAddr, .cmdOperand, .cmdReady, .cmdDone, .memReq, .memWrite, .memByte, .memSpace,
    .memAddr, .memWdata, .memRdata, .memAck, .accu1, .accu2, .accu3, .accu4, .stepPointer,
    .blockStackPtr, .dataBlockBase);
  plt_mem_model mdl (.clk, .reset_n, .memReq, .memWrite, .memByte, .memSpace, .memAddr,
    .memWdata, .memRdata, .memAck);
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction
  task automatic finish_test();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkregs();
    chk("accu1", {rg[0], rg[1]}, accu1);
    chk("accu2", {rg[2], rg[3]}, accu2);
    chk("accu3", {rg[9], rg[10]}, accu3);
    chk("accu4", {rg[11], rg[12]}, accu4);
    chk("step", {rg[5], rg[15]}, {blockStackPtr, stepPointer});
    chk("dbase", {16'h0000, rg[6]}, {16'h0000, dataBlockBase});
  endtask
  task automatic chkm(logic [17:0] a);
    chk("mem", {16'h0000, mm[a]}, {16'h0000, mdl.mem[a]});
  endtask
  task automatic put(logic [17:0] a, logic [15:0] d);
    mm[a] = d;
    mdl.mem[a] = d;
  endtask
  function automatic void push1(logic [31:0] d);
    rg[2] = rg[0];
    rg[3] = rg[1];
    {rg[0], rg[1]} = d;
  endfunction
  // present a command on falling edges until taken; junk operand and parameter afterwards
  task automatic run(plt_op_t op, plt_size_t sz, logic [7:0] p, logic [15:0] a, logic [31:0] d);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    cmdValid = 1'b1;
    cmdOp = op;
    cmdSize = sz;
    cmdParam = p;
    cmdAddr = a;
    cmdOperand = d;
    @(negedge clk);
    cmdValid = 1'b0;
    chk("ready", 32'h00000000, {31'h00000000, cmdReady});
    seed = lfsr(seed);
    cmdOperand = seed;
    cmdParam = seed[7:0];
    n = 0;
    while (cmdDone !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("done", 32'h00000001, {31'h00000000, cmdDone});
  endtask
  task automatic ld(plt_op_t op, logic [31:0] d);
    run(op, SZ_WORD, 8'h00, 16'h0000, d);
    push1(d);
    if (trust) chkregs();
  endtask
  // copy ends set through two fetches; accumulators are not predicted afterwards
  task automatic copy(plt_op_t op, logic [7:0] n, logic [15:0] s, logic [15:0] d);
    int i;
    ld(OP_PATTERN_FETCH, {16'h0000, s});
    trust = 1'b1;
    ld(OP_PATTERN_FETCH, {16'h0000, d});
    for (i = 0; i <= n; i++) begin
      seed = lfsr(seed);
      put({SP_MAIN, s - 16'(i)}, seed[15:0]);
      put({SP_MAIN, d - 16'(i)}, seed[31:16]);
    end
    run(op, SZ_WORD, n, 16'h0000, seed);
    trust = 1'b0;
    for (i = 0; i <= n; i++) begin
      k = {SP_MAIN, s - 16'(i)};
      if (i < n) mm[{SP_MAIN, d - 16'(i)}] = op == OP_BYTE_COPY ? {8'h00, mm[k][7:0]} : mm[k];
      chkm({SP_MAIN, d - 16'(i)});
    end
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    int i, r;
    logic [15:0] a;
    cmdValid = 1'b0;
    cmdOp = OP_PATTERN_FETCH;
    cmdSize = SZ_WORD;
    cmdParam = 8'h00;
    cmdAddr = 16'h0000;
    cmdOperand = 32'h00000000;
    reset_n = 1'b0;
    seed = 32'h0000F941;
    trust = 1'b1;
    for (i = 0; i < 16; i++) rg[i] = 16'h0000;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chkregs();
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ld(i[0] ? OP_FLOAT_FETCH : OP_PATTERN_FETCH, seed);
      run(OP_STACK_PUSH, SZ_WORD, 8'h00, 16'h0000, seed);
      {rg[11], rg[12]} = {rg[9], rg[10]};
      {rg[9], rg[10]} = {rg[2], rg[3]};
      chkregs();
    end
    // formal load then store for byte, word and doubleword
    for (i = 0; i < 3; i++) begin
      a = 16'h0100 + 16'(4 * i);
      k = {SP_MAIN, a};
      put(k, seed[15:0]);
      put(k + 18'h1, seed[31:16]);
      run(OP_FORMAL_LOAD, plt_size_t'(i), 8'h00, a, seed);
      v = {mm[k], mm[k + 18'h1]};
      if (i < 2) v = i == 0 ? {24'h000000, v[23:16]} : {16'h0000, v[31:16]};
      push1(v);
      chkregs();
      put(k + 18'h2, 16'h1234);
      put(k + 18'h3, 16'h5678);
      run(OP_FORMAL_STORE, plt_size_t'(i), 8'h00, a + 16'h0002, seed);
      mm[k + 18'h2] = i == 2 ? rg[0] : i == 1 ? rg[1] : {8'h00, rg[1][7:0]};
      if (i == 2) mm[k + 18'h3] = rg[1];
      chkm(k + 18'h2);
      chkm(k + 18'h3);
    end
    // coded load: count as three bcd digits, time base kept
    r = seed % 1000;
    put({SP_MAIN, 16'h0200}, {6'h08, 10'(r)});
    run(OP_BCD_COUNT_LOAD, SZ_WORD, 8'h00, 16'h0200, seed);
    push1({20'h00002, 4'(r / 100), 4'(r / 10 % 10), 4'(r % 10)});
    chkregs();
    // interface and system words at both ends of the index range
    for (i = 0; i < 4; i++) begin
      k = {i[0] ? SP_SYSTEM : SP_INTERFACE, 8'h00, i[1] ? 8'hFF : 8'h00};
      seed = lfsr(seed);
      put(k, seed[15:0]);
      run(i[0] ? OP_SYS_LOAD : OP_IF_LOAD, SZ_WORD, k[7:0], 16'h0000, seed);
      push1({16'h0000, mm[k]});
      chkregs();
      put(k, ~seed[15:0]);
      run(i[0] ? OP_SYS_STORE : OP_IF_STORE, SZ_WORD, k[7:0], 16'h0000, seed);
      mm[k] = rg[1];
      chkm(k);
    end
    // every register number, odd ones in byte-wide memory
    for (r = 0; r < 16; r++) begin
      a = r[0] ? 16'hEE20 + 16'(r) : 16'hAC20 + 16'(r);
      k = {SP_MAIN, a};
      seed = lfsr(seed);
      put(k, seed[15:0]);
      ld(OP_PATTERN_FETCH, {16'h0000, a});
      run(OP_IREG_FETCH, SZ_WORD, 8'(r), 16'h0000, seed);
      if (!(r inside {4, 7, 8, 13, 14})) rg[r] = r[0] ? {8'hFF, mm[k][7:0]} : mm[k];
      chkregs();
      ld(OP_PATTERN_FETCH, {16'h0000, a});
      put(k, ~seed[31:16]);
      run(OP_IREG_STORE, SZ_WORD, 8'(r), 16'h0000, seed);
      if (!(r inside {4, 7, 8, 13, 14})) mm[k] = r[0] ? {8'h00, rg[r][7:0]} : rg[r];
      chkm(k);
    end
    // each copy keeps source and destination each inside one area: byte-wide cpu to io, user to cpu ram
    copy(OP_BYTE_COPY, 8'h03, 16'hEE80, 16'hF080);
    copy(OP_WORD_COPY, 8'h00, 16'h40FE, 16'hAD10);
    copy(OP_WORD_COPY, 8'hFF, 16'h40FE, 16'hAD10);
    finish_test();
  end
endmodule // plt_load_transfer_unit_tb

// ### testbench/plt_mem_model.sv
// Purpose: program memory and io space facing the load/transfer unit
// Assumes: words keyed by space and address, preloaded by the bench
// Notes: ack delay follows the low address bits, so 0 to 3 wait cycles
`timescale 1ns/100ps
module plt_mem_model
  import plt_pkg::*;
(
  input logic clk,
  input logic reset_n,
  input logic memReq,
  input logic memWrite,
  input logic memByte,
  input plt_space_t memSpace,
  input logic [ADDR_W-1:0] memAddr,
  input logic [WORD_W-1:0] memWdata,
  output logic [WORD_W-1:0] memRdata,
  output logic memAck
);
  logic [WORD_W-1:0] mem [logic [17:0]];
  logic [1:0] waitCnt;
  // read bus toggles outside the ack cycle so stale data never passes for good data
  always @(posedge clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (!reset_n) begin
      waitCnt <= 2'h0;
      memRdata <= 16'hA5C3;
    end else if (memReq && !memAck) begin
      waitCnt <= waitCnt + 2'h1;
      if (waitCnt == memAddr[1:0]) begin
        waitCnt <= 2'h0;
        memAck <= 1'b1;
        if (memWrite) begin
          mem[{memSpace, memAddr}] = memByte ? {8'h00, memWdata[7:0]} : memWdata;
        end else begin
          // byte-wide parts leave the high byte undefined: junk it
          memRdata <= {memByte ? ~mem[{memSpace, memAddr}][7:0] :
            mem[{memSpace, memAddr}][15:8], mem[{memSpace, memAddr}][7:0]};
        end
      end
    end
  end
endmodule // plt_mem_model
